// file: src/lbic_pkg.sv
// Package: register map, field layout, reset values and states of the LCD bias/interrupt block
package lbic_pkg;

   // =====================================================================
   // Register byte offsets (AHB-Lite, one aligned word each)
   localparam logic [7:0] OFS_CTRL0  = 8'h00;  // control_reg_zero
   localparam logic [7:0] OFS_CTRL1  = 8'h04;  // control_reg_one
   localparam logic [7:0] OFS_VCTL   = 8'h08;  // voltage_control_reg
   localparam logic [7:0] OFS_IVEC   = 8'h0C;  // interrupt_vector_reg
   localparam logic [7:0] OFS_ISTAT  = 8'h10;  // sticky status, read only
   localparam logic [7:0] OFS_IEN    = 8'h14;  // interrupt enable
   localparam logic [7:0] OFS_ICLR   = 8'h18;  // write-one clear, reads zero
   localparam logic [7:0] OFS_SYS    = 8'h1C;  // sleep mode and frame divider

   // =====================================================================
   // Field positions
   localparam int CTRL0_ON_BIT    = 0;   // display_on
   localparam int CTRL1_FLAG_LSB  = 0;   // four LCD interrupt flags
   localparam int CTRL1_FRM_BIT   = 0;   // frame_flag within the nibble
   localparam int CTRL1_FRMIE_BIT = 8;   // frame_irq_enable
   localparam int VCTL_EXTV_BIT   = 0;   // external_lcd_voltage_select
   localparam int VCTL_EXTB_BIT   = 1;   // external_bias_select
   localparam int VCTL_CPEN_BIT   = 2;   // charge_pump_enable
   localparam int VCTL_LVL_LSB    = 3;   // lcd_voltage_level, 4 bits
   localparam int SYS_SLEEP_BIT   = 0;   // deepest_sleep_mode
   localparam int SYS_DIV_LSB     = 8;   // frame period minus one, in clocks, 16 bits

   localparam int NUM_FLAGS       = 4;
   localparam int NUM_COM         = 4;
   localparam int NUM_EVT         = 2;   // status: 0 frame, 1 voltage-write hazard

   // =====================================================================
   // Reset values
   localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
   localparam logic [15:0] RST_FRM_DIV = 16'h00FF;

   // Interrupt vector codes
   localparam logic [3:0] IVEC_NONE  = 4'h0;
   localparam logic [3:0] IVEC_FRAME = 4'h2;

   // Supply source for the LCD voltage
   typedef enum logic [2:0]
   {
      SRC_OFF  = 3'b001,
      SRC_PUMP = 3'b010,
      SRC_EXT  = 3'b100
   } lbic_src_t;

   // Voltage control fields travel together
   typedef struct packed
   {
      logic [3:0] level;
      logic       cp_en;
      logic       ext_bias;
      logic       ext_volt;
   } lbic_vctl_t;

endpackage

// file: src/lbic_top.sv
// LCD bias selection, voltage control and frame interrupt with AHB-Lite registers
module lbic_top
   import lbic_pkg::*;
(
   // Clock and reset
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   // AHB-Lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic [31:0]               hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   // Supply selection toward the analog bias network
   output lbic_pkg::lbic_src_t       supply_src,
   output logic [3:0]                pump_level,
   output logic                      ext_bias_en,
   // Common outputs
   output logic [lbic_pkg::NUM_COM-1:0] com_out,
   output logic [lbic_pkg::NUM_COM-1:0] com_oe,
   // Interrupt
   output logic                      irq
);
   import lbic_pkg::*;

   // =====================================================================
   // State
   logic                 disp_on, next_disp_on;
   logic [NUM_FLAGS-1:0] flags, next_flags;
   logic                 frm_ie, next_frm_ie;
   lbic_vctl_t           vctl, next_vctl;
   logic                 sleep, next_sleep;
   logic [15:0]          frm_div, next_frm_div;
   logic [15:0]          frm_cnt, next_frm_cnt;
   logic [NUM_COM-1:0]   com_phase, next_com_phase;
   logic [NUM_EVT-1:0]   istat, next_istat;
   logic [NUM_EVT-1:0]   ien, next_ien;
   // Bus pipeline: the data phase follows the registered address phase
   logic                 wr_pend, next_wr_pend;
   logic                 rd_pend, next_rd_pend;
   logic [7:0]           a_ofs, next_a_ofs;
   logic [31:0]          rdata, next_rdata;
   lbic_src_t            src, next_src;
   logic [3:0]           lvl_o, next_lvl_o;
   logic                 extb_o, next_extb_o;
   logic [NUM_COM-1:0]   com_q, next_com_q;
   logic [NUM_COM-1:0]   oe_q, next_oe_q;
   logic                 irq_q, next_irq_q;

   logic                 frame_tick;
   logic                 addr_ph;
   logic [NUM_EVT-1:0]   evt;
   logic                 vwr_hazard;

   // Only NONSEQ or SEQ transfers to this slave open an access
   assign addr_ph = hsel & hready & htrans[1];

   // =====================================================================
   // Frame timing
   always_comb
   begin
      frame_tick   = 1'b0;
      next_frm_cnt = frm_cnt;
      next_com_phase = com_phase;
      if (!disp_on)
      begin
         // Counter parks at zero while dark so the first frame is full length
         next_frm_cnt   = 16'h0000;
         next_com_phase = {{(NUM_COM-1){1'b0}}, 1'b1};
      end
      else if (frm_cnt >= frm_div)
      begin
         next_frm_cnt   = 16'h0000;
         frame_tick     = 1'b1;
         next_com_phase = {com_phase[NUM_COM-2:0], com_phase[NUM_COM-1]};
      end
      else
      begin
         next_frm_cnt = frm_cnt + 16'h0001;
      end
   end

   // =====================================================================
   // Register bus and control state
   always_comb
   begin
      next_wr_pend = addr_ph & hwrite;
      next_rd_pend = addr_ph & ~hwrite;
      next_a_ofs   = addr_ph ? haddr[7:0] : a_ofs;
      next_disp_on = disp_on;
      next_flags   = flags;
      next_frm_ie  = frm_ie;
      next_vctl    = vctl;
      next_sleep   = sleep;
      next_frm_div = frm_div;
      next_ien     = ien;
      next_istat   = istat;
      vwr_hazard   = 1'b0;
      evt          = '0;

      if (wr_pend)
      begin
         case (a_ofs)
            OFS_CTRL0: next_disp_on = hwdata[CTRL0_ON_BIT];
            OFS_CTRL1:
            begin
               // Writing zero clears a flag; writing one leaves it
               next_flags  = flags & hwdata[CTRL1_FLAG_LSB +: NUM_FLAGS];
               next_frm_ie = hwdata[CTRL1_FRMIE_BIT];
            end
            OFS_VCTL:
            begin
               // Accepted, but flagged: pump restart under a live display glitches it
               next_vctl  = hwdata[6:0];
               vwr_hazard = disp_on;
            end
            OFS_IVEC: next_flags = flags;
            OFS_IEN:  next_ien = hwdata[NUM_EVT-1:0];
            OFS_ICLR: next_istat = istat & ~hwdata[NUM_EVT-1:0];
            OFS_SYS:
            begin
               next_sleep   = hwdata[SYS_SLEEP_BIT];
               next_frm_div = hwdata[SYS_DIV_LSB +: 16];
            end
            // Unmapped offsets and the read-only status ignore writes
            default: next_flags = flags;
         endcase
      end

      // The off transition with the enable still set mirrors the silicon's
      // stray frame flag; software avoids it by dropping the enable first
      if (frame_tick ||
          (wr_pend && a_ofs == OFS_CTRL0 && disp_on && !hwdata[CTRL0_ON_BIT] && frm_ie))
      begin
         next_flags[CTRL1_FRM_BIT] = 1'b1;
      end

      // Set wins over clear
      evt[0] = frame_tick;
      evt[1] = vwr_hazard;
      next_istat = next_istat | evt;
   end

   // =====================================================================
   // Read data
   // Registered, so each word stands only in its data phase
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (addr_ph && !hwrite)
      begin
         case (haddr[7:0])
            OFS_CTRL0: next_rdata[CTRL0_ON_BIT] = disp_on;
            OFS_CTRL1:
            begin
               next_rdata[CTRL1_FLAG_LSB +: NUM_FLAGS] = flags;
               next_rdata[CTRL1_FRMIE_BIT]            = frm_ie;
            end
            OFS_VCTL:  next_rdata[6:0] = vctl;
            OFS_IVEC:
            begin
               // Reading the vector acknowledges nothing; flags clear only by writes
               if (flags[CTRL1_FRM_BIT] && frm_ie)
               begin
                  next_rdata[3:0] = IVEC_FRAME;
               end
               else
               begin
                  next_rdata[3:0] = IVEC_NONE;
               end
            end
            OFS_ISTAT: next_rdata[NUM_EVT-1:0] = istat;
            OFS_IEN:   next_rdata[NUM_EVT-1:0] = ien;
            OFS_SYS:
            begin
               next_rdata[SYS_SLEEP_BIT]      = sleep;
               next_rdata[SYS_DIV_LSB +: 16] = frm_div;
            end
            default:   next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // =====================================================================
   // Supply selection and pins
   // Registered so the analog side never sees a decode glitch
   always_comb
   begin
      next_extb_o = vctl.ext_bias;
      if (vctl.ext_volt && vctl.ext_bias)
      begin
         next_src = SRC_EXT;
      end
      else if (vctl.cp_en)
      begin
         // External select alone is dropped with internal bias
         next_src = SRC_PUMP;
      end
      else
      begin
         next_src = SRC_OFF;
      end
      // Level reaches the pump whenever its enable is set, even with the external source selected
      next_lvl_o = vctl.cp_en ? vctl.level : 4'h0;
      if (sleep)
      begin
         // Undriven commons float; the glass needs its own discharge path
         next_com_q = '0;
         next_oe_q  = '0;
      end
      else
      begin
         next_com_q = disp_on ? com_phase : '0;
         next_oe_q  = {NUM_COM{1'b1}};
      end
      // Level request: stays high until software clears the cause or its enable
      next_irq_q = (|(next_istat & next_ien)) |
                   (next_flags[CTRL1_FRM_BIT] & next_frm_ie);
   end

   // =====================================================================
   // Registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         disp_on   <= 1'b0;
         flags     <= '0;
         frm_ie    <= 1'b0;
         vctl      <= '0;
         sleep     <= 1'b0;
         frm_div   <= RST_FRM_DIV;
         frm_cnt   <= 16'h0000;
         com_phase <= {{(NUM_COM-1){1'b0}}, 1'b1};
         istat     <= '0;
         ien       <= '0;
         wr_pend   <= 1'b0;
         rd_pend   <= 1'b0;
         a_ofs     <= 8'h00;
         rdata     <= RST_ZERO;
         src       <= SRC_OFF;
         lvl_o     <= 4'h0;
         extb_o    <= 1'b0;
         com_q     <= '0;
         oe_q      <= '0;
         irq_q     <= 1'b0;
      end
      else
      begin
         disp_on   <= next_disp_on;
         flags     <= next_flags;
         frm_ie    <= next_frm_ie;
         vctl      <= next_vctl;
         sleep     <= next_sleep;
         frm_div   <= next_frm_div;
         frm_cnt   <= next_frm_cnt;
         com_phase <= next_com_phase;
         istat     <= next_istat;
         ien       <= next_ien;
         wr_pend   <= next_wr_pend;
         rd_pend   <= next_rd_pend;
         a_ofs     <= next_a_ofs;
         rdata     <= next_rdata;
         src       <= next_src;
         lvl_o     <= next_lvl_o;
         extb_o    <= next_extb_o;
         com_q     <= next_com_q;
         oe_q      <= next_oe_q;
         irq_q     <= next_irq_q;
      end
   end

   // =====================================================================
   // Outputs
   assign hrdata      = rdata;
   // Zero wait states and no error response
   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;
   assign supply_src  = src;
   assign pump_level  = lvl_o;
   assign ext_bias_en = extb_o;
   assign com_out     = com_q;
   assign com_oe      = oe_q;
   assign irq         = irq_q;

endmodule // lbic_top

// file: verif/lbic_sva.sv
// Checker: port assertions for the LCD bias and frame interrupt block
module lbic_sva
   import lbic_pkg::*;
(
   // Clock and reset
   input wire logic            hclk,
   input wire logic            hresetn,
   // Bus
   input wire logic            hsel,
   input wire logic [31:0]     haddr,
   input wire logic [1:0]      htrans,
   input wire logic            hwrite,
   input wire logic [2:0]      hsize,
   input wire logic [31:0]     hwdata,
   input wire logic            hready,
   input wire logic [31:0]     hrdata,
   input wire logic            hreadyout,
   input wire logic            hresp,
   // Pins
   input wire lbic_src_t       supply_src,
   input wire logic [3:0]      pump_level,
   input wire logic            ext_bias_en,
   input wire logic [NUM_COM-1:0] com_out,
   input wire logic [NUM_COM-1:0] com_oe,
   input wire logic            irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // =================================================================
   // Shadow of the written control state
   logic       wv, next_wv, on, next_on, sl, next_sl, fie, next_fie;
   logic [7:0] wa, next_wa;
   lbic_vctl_t vc, next_vc;
   always_comb
   begin
      next_wv  = hsel && hready && htrans[1] && hwrite;
      next_wa  = haddr[7:0];
      next_on  = (wv && wa == OFS_CTRL0) ? hwdata[CTRL0_ON_BIT] : on;
      next_fie = (wv && wa == OFS_CTRL1) ? hwdata[CTRL1_FRMIE_BIT] : fie;
      next_sl  = (wv && wa == OFS_SYS) ? hwdata[SYS_SLEEP_BIT] : sl;
      next_vc  = (wv && wa == OFS_VCTL) ? lbic_vctl_t'(hwdata[6:0]) : vc;
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wv  <= 1'b0;
         wa  <= 8'h00;
         on  <= 1'b0;
         fie <= 1'b0;
         sl  <= 1'b0;
         vc  <= '0;
      end
      else
      begin
         wv  <= next_wv;
         wa  <= next_wa;
         on  <= next_on;
         fie <= next_fie;
         sl  <= next_sl;
         vc  <= next_vc;
      end
   end
   // =================================================================
   // Assertions
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ext_supply_a: assert property (
      $stable(vc) && vc.ext_volt && vc.ext_bias |-> supply_src == SRC_EXT)
      else $error("external supply not selected");
   int_bias_a: assert property (
      $stable(vc) && !vc.ext_bias |-> supply_src != SRC_EXT)
      else $error("external supply used with internal bias");
   pump_lvl_a: assert property (
      $stable(vc) |-> pump_level == (vc.cp_en ? vc.level : 4'h0))
      else $error("pump level wrong");
   spur_flag_a: assert property ($fell(on) && fie |-> ##[1:2] irq)
      else $error("no flag on switch off");
   vec_keep_a: assert property (wv && wa == OFS_IVEC && irq |=> irq [*2])
      else $error("vector write dropped interrupt");
   sleep_float_a: assert property (sl && $past(sl) |-> com_oe == '0)
      else $error("commons driven in sleep");
   frame_irq_a: assert property ($rose(on) && fie |-> ##[1:300] irq)
      else $error("no frame interrupt");
   dark_com_a: assert property (!on && !$past(on) |-> com_out == '0)
      else $error("commons active while off");
endmodule // lbic_sva

bind lbic_top lbic_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .supply_src(supply_src),
   .pump_level(pump_level), .ext_bias_en(ext_bias_en), .com_out(com_out),
   .com_oe(com_oe), .irq(irq));

// file: verif/lbic_glass.sv
// Partner model: LCD glass and bias network as seen at the pins
module lbic_glass
   import lbic_pkg::*;
(
   // Pins from the block
   input  wire logic [3:0] com_out,
   input  wire logic [3:0] com_oe,
   input  wire lbic_src_t  supply_src,
   // Levels on the glass
   output logic [3:0]      com_pad,
   output logic            vlcd_ext
);
   timeunit 1ns;
   timeprecision 1ps;
   // Discharge resistors keep undriven commons at ground, no static charge
   assign com_pad  = com_oe & com_out;
   assign vlcd_ext = (supply_src == SRC_EXT);
endmodule // lbic_glass

// file: verif/tb_lbic_top.sv
// Testbench: register-level tests of the LCD bias and frame interrupt block
module tb_lbic_top
   import lbic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, rd, rd_q;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, ext_bias_en, irq, vlcd_ext;
   lbic_src_t   supply_src;
   logic [3:0]  pump_level, com_out, com_oe, com_pad, ph;
   int          num_errors = 0, compares = 0;
   // Supply table: written control, expected source and level
   localparam logic [6:0] VT [4] = '{7'h03, 7'h01, 7'h2C, 7'h29};
   localparam lbic_src_t  ES [4] = '{SRC_EXT, SRC_OFF, SRC_PUMP, SRC_OFF};
   localparam logic [3:0] EL [4] = '{4'h0, 4'h0, 4'h5, 4'h0};

   lbic_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .supply_src(supply_src), .pump_level(pump_level), .ext_bias_en(ext_bias_en),
      .com_out(com_out), .com_oe(com_oe), .irq(irq));
   lbic_glass glass (.com_out(com_out), .com_oe(com_oe), .supply_src(supply_src),
      .com_pad(com_pad), .vlcd_ext(vlcd_ext));

   // =================================================================
   // Bus and compare tasks
   always #2 hclk = ~hclk;
   // Read data is taken as it stood before the edge that ends the data phase
   always @(posedge hclk) rd_q <= hrdata;
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      #1 rd = rd_q;
   endtask
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("[FAIL] %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(e, rd);
   endtask
   task automatic settle();
      repeat (3) @(posedge hclk);
      #1;
   endtask
   task automatic results();
      if (num_errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // =================================================================
   // Tests
   initial
   begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      #1 chk({29'h0, SRC_OFF}, {29'h0, supply_src});
      bus(1'b1, OFS_SYS, 32'h0000_0400);
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, OFS_VCTL, {25'h0, VT[i]});
         settle();
         chk({29'h0, ES[i]}, {29'h0, supply_src});
         chk({28'h0, EL[i]}, {28'h0, pump_level});
         chk({31'h0, VT[i][1]}, {31'h0, ext_bias_en});
         chk({31'h0, ES[i] == SRC_EXT}, {31'h0, vlcd_ext});
      end
      chk(32'h0, {31'h0, hresp});
      chk(32'hF, {28'h0, com_oe});
      chk(32'h0, {28'h0, com_out});
      bus(1'b1, OFS_CTRL1, 32'h0000_0100);
      bus(1'b1, OFS_CTRL0, 32'h0000_0001);
      repeat (12) @(posedge hclk);
      rdchk(OFS_CTRL1, 32'h0000_0101);
      rdchk(OFS_IVEC, {28'h0, IVEC_FRAME});
      chk(32'h1, {31'h0, irq});
      chk(32'h1, {31'h0, $onehot(com_out)});
      ph = com_out;
      // One frame is five clocks with the divider at four
      repeat (5) @(posedge hclk);
      #1 chk({28'h0, ph[2:0], ph[3]}, {28'h0, com_out});
      bus(1'b1, OFS_CTRL1, 32'h0);
      bus(1'b1, OFS_CTRL0, 32'h0);
      bus(1'b1, OFS_CTRL1, 32'h0);
      rdchk(OFS_CTRL1, 32'h0);
      rdchk(OFS_ISTAT, 32'h1);
      chk(32'h0, {28'h0, com_out});
      bus(1'b1, OFS_SYS, 32'h00FF_FF00);
      bus(1'b1, OFS_CTRL0, 32'h1);
      bus(1'b1, OFS_CTRL1, 32'h0000_0100);
      bus(1'b1, OFS_CTRL0, 32'h0);
      settle();
      chk(32'h1, {31'h0, irq});
      bus(1'b1, OFS_IVEC, 32'h0000_000F);
      settle();
      chk(32'h1, {31'h0, irq});
      rdchk(OFS_CTRL1, 32'h0000_0101);
      bus(1'b1, OFS_CTRL1, 32'h0000_0100);
      settle();
      chk(32'h0, {31'h0, irq});
      bus(1'b1, OFS_CTRL1, 32'h0);
      bus(1'b1, OFS_CTRL0, 32'h1);
      bus(1'b1, OFS_VCTL, 32'h0000_0029);
      bus(1'b1, OFS_CTRL0, 32'h0);
      rdchk(OFS_ISTAT, 32'h3);
      bus(1'b1, OFS_IEN, 32'h2);
      settle();
      chk(32'h1, {31'h0, irq});
      bus(1'b1, OFS_IEN, 32'h0);
      settle();
      chk(32'h0, {31'h0, irq});
      bus(1'b1, OFS_IEN, 32'h2);
      bus(1'b1, OFS_ICLR, 32'h3);
      rdchk(OFS_ISTAT, 32'h0);
      rdchk(OFS_ICLR, 32'h0);
      chk(32'h0, {31'h0, irq});
      bus(1'b1, 8'h20, 32'hFFFF_FFFF);
      rdchk(8'h20, 32'h0);
      bus(1'b1, OFS_CTRL0, 32'h1);
      bus(1'b1, OFS_SYS, 32'h0000_FF01);
      settle();
      chk(32'h0, {28'h0, com_oe});
      chk(32'h0, {28'h0, com_pad});
      results();
   end
   initial
   begin
      repeat (20000) @(posedge hclk);
      num_errors++;
      results();
   end
endmodule // tb_lbic_top
